/* File: hdl/apdu_t0_pkg.sv */
package apdu_t0_pkg;
  localparam logic [2:0] HDR_LAST      = 3'h4;
  localparam logic [8:0] LEN_MAX       = 9'h100;
  localparam logic [7:0] INS_GET_RESP  = 8'hC0;
  localparam logic [7:0] SW_OK_HI      = 8'h90;
  localparam logic [7:0] SW_OK_LO      = 8'h00;
  localparam logic [7:0] PB_MORE_DATA  = 8'h61;
  localparam logic [7:0] PB_WRONG_LEN  = 8'h6C;
  localparam logic [7:0] SW_BAD_P12_HI = 8'h6B;
  localparam logic [7:0] SW_BAD_P12_LO = 8'h00;
  localparam logic [7:0] SW_FAIL_HI    = 8'h6F;
  localparam logic [7:0] SW_FAIL_LO    = 8'h00;
  localparam logic [1:0] CASE_1        = 2'h0;
  localparam logic [1:0] CASE_2        = 2'h1;
  localparam logic [1:0] CASE_3        = 2'h2;
  localparam logic [1:0] CASE_4        = 2'h3;
  localparam logic [1:0] BUF_FULL      = 2'h2;

  typedef enum logic [7:0] {
    ST_HDR    = 8'h01,
    ST_DECIDE = 8'h02,
    ST_ACK    = 8'h04,
    ST_BODY   = 8'h08,
    ST_PROC   = 8'h10,
    ST_DATA   = 8'h20,
    ST_SW1    = 8'h40,
    ST_SW2    = 8'h80
  } t0_state_t;
endpackage

/* File: hdl/apdu_byte_transport_cases.sv */
`timescale 1ns/100ps
// Summary of operation
// - case 3 status only after full body and processing, except bad P1 or P2 (6B 00 at once); success is 90 00
// - case 4 success after body answers 61 and the response length
// - case 4 failure after body answers a status word only, no data
// - GET RESPONSE after case 4 is handled as a case 2 command whose available count is the pending response length, not app_avail
// - short GET RESPONSE sends leading bytes then 61 and the remainder
// - case 2 length too long or 00 under 256 answers 6C and available count
// - failing case 2 or case 4 commands never answer 90 00
// - exact case 2 length sends all bytes after ack, then 90 00
// - case 2 length below available sends that many bytes then 61 xx
// - GET RESPONSE answers C0, then data, then the final status word
// - bad P1 or P2 answers status 6B 00
module apdu_byte_transport_cases (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  output logic            rx_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_byte,
  input  wire logic       tx_ready,
  output logic            hdr_valid,
  output logic [7:0]      hdr_cla,
  output logic [7:0]      hdr_ins,
  output logic [7:0]      hdr_p1,
  output logic [7:0]      hdr_p2,
  output logic [7:0]      hdr_p3,
  output logic            hdr_get_resp,
  input  wire logic       app_resp_valid,
  input  wire logic       app_p12_ok,
  input  wire logic [1:0] app_case,
  input  wire logic       app_ok,
  input  wire logic [8:0] app_avail,
  input  wire logic       app_single_step,
  input  wire logic [7:0] app_sw1,
  input  wire logic [7:0] app_sw2,
  output logic            body_valid,
  output logic [7:0]      body_byte,
  input  wire logic       app_done_valid,
  input  wire logic [8:0] app_resp_len,
  input  wire logic       data_valid,
  input  wire logic [7:0] data_byte,
  output logic            data_ready
);
  apdu_t0_pkg::t0_state_t state;
  logic [2:0]             hcnt;
  logic [8:0]             cnt;
  logic [8:0]             rem;
  logic [8:0]             pend;
  logic                   is_c2;
  logic                   is_c4;
  logic                   step;
  logic                   nack;
  logic [7:0]             sw1;
  logic [7:0]             sw2;
  logic [7:0]             buf_mem [0:1];
  logic                   wr_ptr;
  logic                   rd_ptr;
  logic [1:0]             buf_cnt;

  // --- decode ---
  wire       buf_in_ready = (buf_cnt != apdu_t0_pkg::BUF_FULL);
  wire       rx_fire      = rx_valid & rx_ready;
  wire       is_gr        = (hdr_ins == apdu_t0_pkg::INS_GET_RESP);
  wire [8:0] le           = (hdr_p3 == 8'h00) ? apdu_t0_pkg::LEN_MAX : {1'b0, hdr_p3};
  wire [8:0] avail_eff    = is_gr ? pend : app_avail;
  wire       too_long     = le > avail_eff;
  wire       app_sw_ok    = (app_sw1 == apdu_t0_pkg::SW_OK_HI) &&
                            (app_sw2 == apdu_t0_pkg::SW_OK_LO);
  wire [7:0] fail_hi      = app_sw_ok ? apdu_t0_pkg::SW_FAIL_HI : app_sw1;
  wire [7:0] fail_lo      = app_sw_ok ? apdu_t0_pkg::SW_FAIL_LO : app_sw2;
  wire [7:0] ack_byte     = nack ? ~hdr_ins : hdr_ins;
  wire       is_body_case = (app_case == apdu_t0_pkg::CASE_3) ||
                            (app_case == apdu_t0_pkg::CASE_4);
  wire       decide_go    = (state == apdu_t0_pkg::ST_DECIDE) && app_resp_valid;
  wire       c2_dec       = is_gr || (app_case == apdu_t0_pkg::CASE_2);

  wire       push_valid   = (state == apdu_t0_pkg::ST_ACK) ||
                            (state == apdu_t0_pkg::ST_SW1) ||
                            (state == apdu_t0_pkg::ST_SW2) ||
                            ((state == apdu_t0_pkg::ST_DATA) && data_valid);
  wire [7:0] push_byte    = (state == apdu_t0_pkg::ST_ACK)  ? ack_byte :
                            (state == apdu_t0_pkg::ST_SW1)  ? sw1 :
                            (state == apdu_t0_pkg::ST_SW2)  ? sw2 : data_byte;
  wire       push_fire    = push_valid & buf_in_ready;
  wire       pop_fire     = tx_valid & tx_ready;

  assign rx_ready     = (state == apdu_t0_pkg::ST_HDR) || (state == apdu_t0_pkg::ST_BODY);
  assign data_ready   = (state == apdu_t0_pkg::ST_DATA) && buf_in_ready;
  assign tx_valid     = (buf_cnt != 2'h0);
  assign tx_byte      = buf_mem[rd_ptr];
  assign hdr_get_resp = is_gr;

  // two-entry transmit buffer: a stalled receiver loses no byte
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      buf_cnt    <= 2'h0;
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
    end else begin
      if (push_fire) begin
        buf_mem[wr_ptr] <= push_byte;
        wr_ptr          <= ~wr_ptr;
      end
      if (pop_fire)
        rd_ptr <= ~rd_ptr;
      buf_cnt <= buf_cnt + {1'b0, push_fire} - {1'b0, pop_fire};
    end
  end

  // --- command sequencer ---
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state      <= apdu_t0_pkg::ST_HDR;
      hcnt       <= 3'h0;
      cnt        <= 9'h000;
      rem        <= 9'h000;
      pend       <= 9'h000;
      is_c2      <= 1'b0;
      is_c4      <= 1'b0;
      step       <= 1'b0;
      nack       <= 1'b0;
      sw1        <= 8'h00;
      sw2        <= 8'h00;
      hdr_valid  <= 1'b0;
      hdr_cla    <= 8'h00;
      hdr_ins    <= 8'h00;
      hdr_p1     <= 8'h00;
      hdr_p2     <= 8'h00;
      hdr_p3     <= 8'h00;
      body_valid <= 1'b0;
      body_byte  <= 8'h00;
    end else begin
      hdr_valid  <= 1'b0;
      body_valid <= 1'b0;
      unique case (state)
        apdu_t0_pkg::ST_HDR: if (rx_fire) begin
          unique case (hcnt)
            3'h0: hdr_cla <= rx_byte;
            3'h1: hdr_ins <= rx_byte;
            3'h2: hdr_p1  <= rx_byte;
            3'h3: hdr_p2  <= rx_byte;
            default: hdr_p3 <= rx_byte;
          endcase
          if (hcnt == apdu_t0_pkg::HDR_LAST) begin
            hcnt      <= 3'h0;
            hdr_valid <= 1'b1;
            state     <= apdu_t0_pkg::ST_DECIDE;
          end else begin
            hcnt <= hcnt + 3'h1;
          end
        end
        apdu_t0_pkg::ST_DECIDE: if (app_resp_valid) begin
          is_c2 <= c2_dec;
          is_c4 <= !is_gr && (app_case == apdu_t0_pkg::CASE_4);
          nack  <= app_single_step && !c2_dec;
          step  <= app_single_step;
          if (!is_gr)
            pend <= 9'h000;
          state <= apdu_t0_pkg::ST_SW1;
          if (!app_p12_ok) begin
            sw1 <= apdu_t0_pkg::SW_BAD_P12_HI;
            sw2 <= apdu_t0_pkg::SW_BAD_P12_LO;
          end else if (c2_dec) begin
            if (!app_ok) begin
              sw1 <= fail_hi;
              sw2 <= fail_lo;
            end else if (too_long) begin
              sw1 <= apdu_t0_pkg::PB_WRONG_LEN;
              sw2 <= avail_eff[7:0];
            end else begin
              cnt   <= le;
              rem   <= avail_eff - le;
              state <= apdu_t0_pkg::ST_ACK;
            end
          end else if (is_body_case) begin
            cnt   <= {1'b0, hdr_p3};
            state <= (hdr_p3 == 8'h00) ? apdu_t0_pkg::ST_PROC : apdu_t0_pkg::ST_ACK;
          end else begin
            sw1 <= app_ok ? apdu_t0_pkg::SW_OK_HI : fail_hi;
            sw2 <= app_ok ? apdu_t0_pkg::SW_OK_LO : fail_lo;
          end
        end
        apdu_t0_pkg::ST_ACK: if (push_fire)
          state <= is_c2 ? apdu_t0_pkg::ST_DATA : apdu_t0_pkg::ST_BODY;
        apdu_t0_pkg::ST_BODY: if (rx_fire) begin
          body_valid <= 1'b1;
          body_byte  <= rx_byte;
          cnt        <= cnt - 9'h001;
          if (cnt == 9'h001) begin
            state <= apdu_t0_pkg::ST_PROC;
          end else if (step) begin
            nack  <= 1'b1;
            state <= apdu_t0_pkg::ST_ACK;
          end
        end
        apdu_t0_pkg::ST_PROC: if (app_done_valid) begin
          state <= apdu_t0_pkg::ST_SW1;
          if (is_c4 && app_ok) begin
            sw1  <= apdu_t0_pkg::PB_MORE_DATA;
            sw2  <= app_resp_len[7:0];
            pend <= app_resp_len;
          end else if (app_ok) begin
            sw1 <= apdu_t0_pkg::SW_OK_HI;
            sw2 <= apdu_t0_pkg::SW_OK_LO;
          end else begin
            sw1 <= fail_hi;
            sw2 <= fail_lo;
          end
        end
        apdu_t0_pkg::ST_DATA: if (push_fire) begin
          cnt <= cnt - 9'h001;
          if (cnt == 9'h001) begin
            state <= apdu_t0_pkg::ST_SW1;
            pend  <= rem;
            sw1   <= (rem != 9'h000) ? apdu_t0_pkg::PB_MORE_DATA : apdu_t0_pkg::SW_OK_HI;
            sw2   <= (rem != 9'h000) ? rem[7:0] : apdu_t0_pkg::SW_OK_LO;
          end
        end
        apdu_t0_pkg::ST_SW1: if (push_fire)
          state <= apdu_t0_pkg::ST_SW2;
        apdu_t0_pkg::ST_SW2: if (push_fire)
          state <= apdu_t0_pkg::ST_HDR;
        default: state <= apdu_t0_pkg::ST_HDR;
      endcase
    end
  end

  // --- checks ---
  a_case3_status:
  assert property (@(posedge mclk) disable iff (rst)
    (state == apdu_t0_pkg::ST_BODY) ##1 (state == apdu_t0_pkg::ST_PROC) |-> cnt == 9'h000)
    else $error("status stage entered before the body was complete");
  a_case4_more:
  assert property (@(posedge mclk) disable iff (rst)
    (state == apdu_t0_pkg::ST_PROC) && app_done_valid && is_c4 && app_ok
    |=> (state == apdu_t0_pkg::ST_SW1) && (sw1 == apdu_t0_pkg::PB_MORE_DATA)
        && (sw2 == $past(app_resp_len[7:0])))
    else $error("case 4 success did not answer 61 with length");
  a_fail_not_ok:
  assert property (@(posedge mclk) disable iff (rst)
    (state == apdu_t0_pkg::ST_PROC) && app_done_valid && !app_ok
    |=> !((sw1 == apdu_t0_pkg::SW_OK_HI) && (sw2 == apdu_t0_pkg::SW_OK_LO))
        ##1 (state != apdu_t0_pkg::ST_DATA))
    else $error("failed command answered 90 00 or sent data");
  a_wrong_len:
  assert property (@(posedge mclk) disable iff (rst)
    decide_go && app_p12_ok && c2_dec && app_ok && too_long
    |=> (sw1 == apdu_t0_pkg::PB_WRONG_LEN) && (sw2 == $past(avail_eff[7:0]))
        && (state == apdu_t0_pkg::ST_SW1))
    else $error("length mismatch did not answer 6C");
  a_bad_param:
  assert property (@(posedge mclk) disable iff (rst)
    decide_go && !app_p12_ok
    |=> (sw1 == apdu_t0_pkg::SW_BAD_P12_HI) && (sw2 == apdu_t0_pkg::SW_BAD_P12_LO))
    else $error("bad parameters did not answer 6B 00");
  a_get_resp_ack:
  assert property (@(posedge mclk) disable iff (rst)
    (state == apdu_t0_pkg::ST_ACK) && is_gr && !nack
    |-> push_byte == apdu_t0_pkg::INS_GET_RESP)
    else $error("GET RESPONSE not acknowledged with C0");
  a_partial_more:
  assert property (@(posedge mclk) disable iff (rst)
    (state == apdu_t0_pkg::ST_DATA) && push_fire && (cnt == 9'h001) && (rem != 9'h000)
    |=> (sw1 == apdu_t0_pkg::PB_MORE_DATA) && (pend == $past(rem)))
    else $error("partial transfer did not answer 61 with remainder");
  a_exact_done:
  assert property (@(posedge mclk) disable iff (rst)
    (state == apdu_t0_pkg::ST_DATA) && push_fire && (cnt == 9'h001) && (rem == 9'h000)
    |=> (sw1 == apdu_t0_pkg::SW_OK_HI) ##[1:1000] (state == apdu_t0_pkg::ST_HDR))
    else $error("exact transfer did not end with 90 00");
  a_single_step:
  assert property (@(posedge mclk) disable iff (rst)
    (state == apdu_t0_pkg::ST_BODY) && rx_fire && step && (cnt > 9'h001)
    |=> (state == apdu_t0_pkg::ST_ACK) && (ack_byte == ~hdr_ins))
    else $error("single step mode did not send complemented INS");
  c_case3_ok: cover property (@(posedge mclk) disable iff (rst)
    (state == apdu_t0_pkg::ST_PROC) && app_done_valid && app_ok && !is_c4);
  c_case4_more: cover property (@(posedge mclk) disable iff (rst)
    (state == apdu_t0_pkg::ST_PROC) && app_done_valid && app_ok && is_c4);
  c_wrong_len: cover property (@(posedge mclk) disable iff (rst)
    decide_go && app_p12_ok && c2_dec && app_ok && too_long);
  c_partial_gr: cover property (@(posedge mclk) disable iff (rst)
    (state == apdu_t0_pkg::ST_DATA) && is_gr && push_fire && (cnt == 9'h001) && (rem != 9'h000));
  c_buf_full: cover property (@(posedge mclk) disable iff (rst) !buf_in_ready);
endmodule

/* File: tb/term_model.sv */
`timescale 1ns/100ps
module term_model (
  input  wire logic       mclk,
  input  wire logic       slow,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            tx_ready
);
  logic [7:0] rq[$];

  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    tx_ready = 1'b0;
  end

  task automatic put(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_byte  <= b;
    do @(posedge mclk); while (rx_ready !== 1'b1);
  endtask

  // released line shows the inverse of the last byte
  task automatic rel();
    rx_valid <= 1'b0;
    rx_byte  <= ~rx_byte;
  endtask

  task automatic get(output logic [7:0] b);
    if (slow) begin
      tx_ready <= 1'b0;
      @(posedge mclk);
    end
    tx_ready <= 1'b1;
    do @(posedge mclk); while (!(tx_valid === 1'b1 && tx_ready === 1'b1));
    b = tx_byte;
    rq.push_back(b);
  endtask

  // one command: header, then follow the card's procedure bytes
  task automatic xfer(input logic [39:0] h, input logic dat_in);
    logic [7:0] b;
    int         left;
    rq   = {};
    left = (dat_in && h[7:0] == 8'h00) ? 256 : int'(h[7:0]);
    for (int i = 4; i >= 0; i--) put(h[8*i+:8]);
    rel();
    forever begin
      get(b);
      if (b == 8'h60) continue;
      if (b == h[31:24] && dat_in && left > 0) begin
        repeat (left) get(b);
        left = 0;
      end else if (b == h[31:24] && !dat_in && left > 0) begin
        tx_ready <= 1'b0;
        while (left > 0) begin
          put(8'h10 + h[7:0] - left[7:0]);
          left--;
        end
        rel();
      end else if (b == ~h[31:24] && !dat_in && left > 0) begin
        tx_ready <= 1'b0;
        put(8'h10 + h[7:0] - left[7:0]);
        left--;
        rel();
      end else begin
        get(b);
        break;
      end
    end
    tx_ready <= 1'b0;
  endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [7:0] ins, p3, e1, e2;
    logic [8:0] av, nd;
    logic [1:0] cs;
    logic       p12, ok, ss;
  } row_t;
  logic       mclk, rst, rx_valid, rx_ready, tx_valid, tx_ready, hdr_valid, hdr_get_resp;
  logic       app_resp_valid, app_p12_ok, app_ok, app_single_step, body_valid, slow;
  logic       app_done_valid, data_valid, data_ready;
  logic [1:0] app_case;
  logic [8:0] app_avail, app_resp_len;
  logic [7:0] rx_byte, tx_byte, hdr_cla, hdr_ins, hdr_p1, hdr_p2, hdr_p3;
  logic [7:0] app_sw1, app_sw2, body_byte, data_byte, dx;
  logic [7:0] bq[$];
  int         n_errors, cmp_count, n_hdr;
  row_t       rows [0:14] = '{
    '{8'hD6, 8'h0B, 8'h90, 8'h00, 9'h000, 9'h000, 2'h2, 1'b1, 1'b1, 1'b0},
    '{8'hD6, 8'h03, 8'h90, 8'h00, 9'h000, 9'h000, 2'h2, 1'b1, 1'b1, 1'b1},
    '{8'hD6, 8'h0B, 8'h6B, 8'h00, 9'h000, 9'h000, 2'h2, 1'b0, 1'b1, 1'b0},
    '{8'hD6, 8'h04, 8'h65, 8'h81, 9'h000, 9'h000, 2'h2, 1'b1, 1'b0, 1'b0},
    '{8'hB0, 8'h00, 8'h6C, 8'h0B, 9'h00B, 9'h000, 2'h1, 1'b1, 1'b1, 1'b0},
    '{8'hB0, 8'h0B, 8'h90, 8'h00, 9'h00B, 9'h00B, 2'h1, 1'b1, 1'b1, 1'b0},
    '{8'hB0, 8'h05, 8'h61, 8'h06, 9'h00B, 9'h005, 2'h1, 1'b1, 1'b1, 1'b0},
    '{8'hB0, 8'h0B, 8'h6F, 8'h00, 9'h00B, 9'h000, 2'h1, 1'b1, 1'b0, 1'b0},
    '{8'hB0, 8'h00, 8'h90, 8'h00, 9'h100, 9'h100, 2'h1, 1'b1, 1'b1, 1'b0},
    '{8'hA4, 8'h02, 8'h61, 8'h07, 9'h000, 9'h000, 2'h3, 1'b1, 1'b1, 1'b0},
    '{8'hC0, 8'h03, 8'h61, 8'h04, 9'h000, 9'h003, 2'h1, 1'b1, 1'b1, 1'b0},
    '{8'hC0, 8'h04, 8'h90, 8'h00, 9'h000, 9'h004, 2'h1, 1'b1, 1'b1, 1'b0},
    '{8'hA4, 8'h02, 8'h62, 8'h83, 9'h000, 9'h000, 2'h3, 1'b1, 1'b0, 1'b0},
    '{8'hC0, 8'h00, 8'h6C, 8'h00, 9'h000, 9'h000, 2'h1, 1'b1, 1'b1, 1'b0},
    '{8'hA4, 8'h02, 8'h6A, 8'h82, 9'h000, 9'h000, 2'h3, 1'b1, 1'b0, 1'b0}
  };

  apdu_byte_transport_cases dut (
    .mclk, .rst, .rx_valid, .rx_byte, .rx_ready, .tx_valid, .tx_byte, .tx_ready, .hdr_valid,
    .hdr_cla, .hdr_ins, .hdr_p1, .hdr_p2, .hdr_p3, .hdr_get_resp, .app_resp_valid,
    .app_p12_ok, .app_case, .app_ok, .app_avail, .app_single_step, .app_sw1, .app_sw2,
    .body_valid, .body_byte, .app_done_valid, .app_resp_len, .data_valid, .data_byte,
    .data_ready
  );
  term_model tm (.mclk, .slow, .rx_ready, .tx_valid, .tx_byte, .rx_valid, .rx_byte, .tx_ready);

  always #25 mclk = ~mclk;

  always @(posedge mclk) begin
    if (body_valid === 1'b1) bq.push_back(body_byte);
    if (hdr_valid === 1'b1) n_hdr++;
    if (data_ready === 1'b1 && data_valid === 1'b1) data_byte <= data_byte + 8'h01;
    // fast runs stall the response stream every other cycle
    data_valid <= slow | ~data_valid;
  end

  task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic run(input row_t w, input logic s);
    int         nb;
    int         h0;
    logic [7:0] ex[$];
    @(posedge mclk);
    slow            <= s;
    app_case        <= w.cs;
    app_p12_ok      <= w.p12;
    app_ok          <= w.ok;
    app_avail       <= w.av;
    app_single_step <= w.ss;
    app_resp_len    <= {1'b0, w.e2};
    // 6F rows feed a 90 00 failure status
    app_sw1         <= (w.e1 == 8'h6F) ? 8'h90 : w.e1;
    app_sw2         <= w.e2;
    bq = {};
    nb = (w.p12 && w.cs[1] && w.ins != 8'hC0) ? int'(w.p3) : 0;
    for (int i = 0; i < nb; i++) if (w.ss || i == 0) ex.push_back(w.ss ? ~w.ins : w.ins);
    if (w.nd != 9'h000) ex.push_back(w.ins);
    for (int i = 0; i < w.nd; i++) begin
      ex.push_back(dx);
      dx++;
    end
    ex.push_back(w.e1);
    ex.push_back(w.e2);
    @(posedge mclk);
    h0 = n_hdr;
    tm.xfer({8'h00, w.ins, 8'h01, 8'h02, w.p3}, w.ins == 8'hC0 || !w.cs[1]);
    check("rsp_count", 9'(tm.rq.size()), 9'(ex.size()));
    foreach (ex[i]) check("rsp_byte", {1'b0, tm.rq[i]}, {1'b0, ex[i]});
    check("body_count", 9'(bq.size()), 9'(nb));
    foreach (bq[i]) check("body_byte", {1'b0, bq[i]}, 9'(8'h10 + i));
    check("get_resp", {8'h00, hdr_get_resp}, {8'h00, w.ins == 8'hC0});
    check("hdr_pulse", 9'(n_hdr - h0), 9'h001);
    check("hdr_ins", {1'b0, hdr_ins}, {1'b0, w.ins});
    check("hdr_p3", {1'b0, hdr_p3}, {1'b0, w.p3});
    check("hdr_cla", {1'b0, hdr_cla}, 9'h000);
    check("hdr_p1", {1'b0, hdr_p1}, 9'h001);
    check("hdr_p2", {1'b0, hdr_p2}, 9'h002);
    $display("test ins %h p3 %h done", w.ins, w.p3);
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    slow = 1'b0;
    {app_p12_ok, app_ok, app_single_step, app_case} = '0;
    {app_avail, app_resp_len, app_sw1, app_sw2} = '0;
    {app_resp_valid, app_done_valid, data_valid} = 3'h7;
    data_byte = 8'h00;
    dx = 8'h00;
    repeat (16) @(posedge mclk);
    check("rx_ready_rst", {8'h00, rx_ready}, 9'h001);
    check("tx_valid_rst", {8'h00, tx_valid}, 9'h000);
    check("data_ready_rst", {8'h00, data_ready}, 9'h000);
    rst <= 1'b0;
    $display("test reset done");
    foreach (rows[r]) run(rows[r], r[0] ^ r[3]);
    // partial header, then reset mid-command
    tm.put(8'h00);
    tm.put(8'hB0);
    tm.rel();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    check("rx_ready_mid", {8'h00, rx_ready}, 9'h001);
    check("hdr_ins_mid", {1'b0, hdr_ins}, 9'h000);
    check("tx_valid_mid", {8'h00, tx_valid}, 9'h000);
    run('{8'hB0, 8'h02, 8'h90, 8'h00, 9'h002, 9'h002, 2'h1, 1'b1, 1'b1, 1'b0}, 1'b1);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    complete_run();
  end
endmodule
